// *** fspg_decode.sv ***
package fspg_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int ADDR_W_DEF = 16;
  localparam int STALLING_SECTION_WORDS_DEF = 4096;
  localparam int BOOT_WORDS_MIN = 512;
  localparam int BOOT_WORDS_MAX = 4096;

  // ------------------------------------------------------------
  // register map, byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_LOCK_OFS = 8'h04;
  localparam logic [7:0] REG_STAT_OFS = 8'h08;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CTRL_RRE_BIT = 0;
  localparam int LOCK_APP_LSB = 0;
  localparam int LOCK_BOOT_LSB = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PROG_BIT = 1;
  localparam int STAT_HALT_BIT = 2;
  localparam int STAT_OK_BIT = 3;
  localparam logic [1:0] LOCK_UNPROG = 2'h3;

  // ------------------------------------------------------------
  // commands and states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_LOAD,
    OP_ERASE,
    OP_WRITE,
    OP_LOCKSET
  } fspg_op_t;

  typedef enum logic {
    ST_IDLE,
    ST_PROG
  } fspg_state_t;

  // boot size in words, fuses 11 give the smallest section
  function automatic int boot_words(input logic [1:0] fuses);
    boot_words = BOOT_WORDS_MIN << (2'h3 - fuses);
  endfunction : boot_words
endpackage : fspg_pkg

`timescale 1ns/1ps
module fspg_section_decode #(
  parameter int ADDR_W = fspg_pkg::ADDR_W_DEF,
  parameter int STALLING_SECTION_WORDS = fspg_pkg::STALLING_SECTION_WORDS_DEF
) (
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [1:0] boot_size_fuses_i,
  output logic in_boot_o,
  output logic in_stalling_section_o
);
  import fspg_pkg::*;
  logic [ADDR_W-1:0] boot_mask;
  localparam logic [ADDR_W-1:0] STALLING_SECTION_MASK = ADDR_W'(STALLING_SECTION_WORDS - 1);

  // both sections sit at the top of flash, sizes are powers of two
  assign boot_mask = ADDR_W'(boot_words(boot_size_fuses_i) - 1);
  assign in_boot_o = &(addr_i | boot_mask);
  assign in_stalling_section_o = &(addr_i | STALLING_SECTION_MASK);
endmodule : fspg_section_decode

// *** fspg_guard.sv ***
// How it works
// - store from application code never programs
// - boot code may program any page
// - boot/application split set by fuses
// - fixed concurrent/stalling boundary, not configurable
// - concurrent-section program keeps cpu running
// - stalling-section program halts cpu until done
// - boot section always inside stalling section
// - busy flag reads one while blocked
// - read-enable after completion or load clears busy
// - lock bits only programmed; chip erase or reset restores
// - general write lock ignored for stores
// - general read/write lock ignored for loads
// - app lock 11 free, 10 blocks stores
// - app lock 00 blocks both, 01 loads
// - app lock 0x suppresses irqs in application if vectors in boot
// - boot lock 11 free, 10 blocks stores
// - boot lock 00 blocks both, 01 loads
// - boot lock 0x suppresses irqs in boot if vectors in application
// - the two lock fields act independently
`timescale 1ns/1ps
module fspg_guard #(
  parameter int ADDR_W = fspg_pkg::ADDR_W_DEF,
  parameter int STALLING_SECTION_WORDS = fspg_pkg::STALLING_SECTION_WORDS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] boot_size_fuses_i,
  input wire logic spm_req_i,
  input wire fspg_pkg::fspg_op_t spm_op_i,
  input wire logic [ADDR_W-1:0] spm_pc_i,
  input wire logic [ADDR_W-1:0] spm_addr_i,
  input wire logic [3:0] spm_lock_i,
  output logic spm_done_o,
  output logic spm_ok_o,
  input wire logic [ADDR_W-1:0] lpm_pc_i,
  input wire logic [ADDR_W-1:0] lpm_addr_i,
  output logic lpm_allow_o,
  input wire logic [ADDR_W-1:0] exec_pc_i,
  input wire logic ivec_in_boot_i,
  output logic irq_suppress_o,
  input wire logic prog_lock_we_i,
  input wire logic [3:0] prog_lock_i,
  input wire logic chip_erase_i,
  output logic flash_start_o,
  output fspg_pkg::fspg_op_t flash_op_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic flash_done_i,
  output logic cpu_halt_o,
  output logic rww_read_blocked_o
);
  import fspg_pkg::*;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // a boot section larger than the stalling region would let boot code stall itself
  if (STALLING_SECTION_WORDS < BOOT_WORDS_MAX || STALLING_SECTION_WORDS >= (1 << ADDR_W) ||
      (STALLING_SECTION_WORDS & (STALLING_SECTION_WORDS - 1)) != 0) begin : g_bad_stalling_section
    $error("stalling section size unusable");
  end
  if (ADDR_W < 13 || ADDR_W > 24) begin : g_bad_addr
    $error("address width out of range");
  end

  // ------------------------------------------------------------
  // section decode
  // ------------------------------------------------------------
  localparam int N_DEC = 5;
  logic [ADDR_W-1:0] dec_addr [N_DEC];
  logic [N_DEC-1:0] dec_boot;
  logic [N_DEC-1:0] dec_stalling_section;

  assign dec_addr[0] = spm_pc_i;
  assign dec_addr[1] = spm_addr_i;
  assign dec_addr[2] = lpm_pc_i;
  assign dec_addr[3] = lpm_addr_i;
  assign dec_addr[4] = exec_pc_i;

  for (genvar i = 0; i < N_DEC; i++) begin : g_dec
    fspg_section_decode #(
      .ADDR_W(ADDR_W),
      .STALLING_SECTION_WORDS(STALLING_SECTION_WORDS)
    ) u_dec (
      .addr_i(dec_addr[i]),
      .boot_size_fuses_i(boot_size_fuses_i),
      .in_boot_o(dec_boot[i]),
      .in_stalling_section_o(dec_stalling_section[i])
    );
  end

  logic pc_boot;
  logic tgt_boot;
  logic tgt_stalling_section;
  assign pc_boot = dec_boot[0];
  assign tgt_boot = dec_boot[1];
  assign tgt_stalling_section = dec_stalling_section[1];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    fspg_state_t st;
    logic busy;
    logic halt;
    logic [1:0] app_lock;
    logic [1:0] boot_lock;
    logic ack;
    logic [31:0] rdat;
    logic fl_start;
    fspg_op_t fl_op;
    logic [ADDR_W-1:0] fl_addr;
    logic done;
    logic ok;
  } fspg_regs_t;

  fspg_regs_t q;
  fspg_regs_t d;

  logic wb_req;
  logic wb_wr;
  logic rre_wr;
  logic lock_wr;
  logic store_allowed;

  assign wb_req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master samples ack
  assign wb_wr = wb_req & wb_we_i & q.ack & wb_sel_i[0];
  assign rre_wr = wb_wr && (wb_adr_i == REG_CTRL_OFS) && wb_dat_i[CTRL_RRE_BIT];
  assign lock_wr = wb_wr && (wb_adr_i == REG_LOCK_OFS);
  // general lock modes have no input here: stores see only the section locks
  assign store_allowed = tgt_boot ? q.boot_lock[0] : q.app_lock[0];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.fl_start = 1'b0;
    d.done = 1'b0;
    d.ack = wb_req & ~q.ack;
    d.rdat = 32'h0;
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_LOCK_OFS: begin
          d.rdat[LOCK_APP_LSB +: 2] = q.app_lock;
          d.rdat[LOCK_BOOT_LSB +: 2] = q.boot_lock;
        end
        REG_STAT_OFS: begin
          d.rdat[STAT_BUSY_BIT] = q.busy;
          d.rdat[STAT_PROG_BIT] = (q.st == ST_PROG);
          d.rdat[STAT_HALT_BIT] = q.halt;
          d.rdat[STAT_OK_BIT] = q.ok;
        end
        default: d.rdat = 32'h0;
      endcase
    end
    // lock bits can only move towards programmed (zero)
    if (lock_wr) begin
      d.app_lock = d.app_lock & wb_dat_i[LOCK_APP_LSB +: 2];
      d.boot_lock = d.boot_lock & wb_dat_i[LOCK_BOOT_LSB +: 2];
    end
    if (prog_lock_we_i) begin
      d.app_lock = d.app_lock & prog_lock_i[LOCK_APP_LSB +: 2];
      d.boot_lock = d.boot_lock & prog_lock_i[LOCK_BOOT_LSB +: 2];
    end
    // clear comes first so a new busy set below wins
    if (rre_wr && q.st == ST_IDLE) begin
      d.busy = 1'b0;
    end
    unique case (q.st)
      ST_IDLE: begin
        if (spm_req_i) begin
          d.done = 1'b1;
          d.ok = 1'b0;
          if (pc_boot) begin
            unique case (spm_op_i)
              OP_LOAD: begin
                d.fl_start = 1'b1;
                d.fl_op = OP_LOAD;
                d.fl_addr = spm_addr_i;
                d.busy = 1'b0;
                d.ok = 1'b1;
              end
              OP_LOCKSET: begin
                d.app_lock = d.app_lock & spm_lock_i[LOCK_APP_LSB +: 2];
                d.boot_lock = d.boot_lock & spm_lock_i[LOCK_BOOT_LSB +: 2];
                d.ok = 1'b1;
              end
              OP_ERASE, OP_WRITE: begin
                if (store_allowed) begin
                  d.fl_start = 1'b1;
                  d.fl_op = spm_op_i;
                  d.fl_addr = spm_addr_i;
                  d.st = ST_PROG;
                  d.done = 1'b0;
                  d.halt = tgt_stalling_section;
                  d.busy = d.busy | ~tgt_stalling_section;
                end
              end
            endcase
          end
        end
      end
      ST_PROG: begin
        // cpu stays halted for the whole operation only when the target is in the stalling section
        if (flash_done_i) begin
          d.st = ST_IDLE;
          d.halt = 1'b0;
          d.done = 1'b1;
          d.ok = 1'b1;
        end
      end
    endcase
    if (chip_erase_i) begin
      d.app_lock = LOCK_UNPROG;
      d.boot_lock = LOCK_UNPROG;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.st <= ST_IDLE;
      q.busy <= 1'b0;
      q.halt <= 1'b0;
      q.app_lock <= LOCK_UNPROG;
      q.boot_lock <= LOCK_UNPROG;
      q.ack <= 1'b0;
      q.rdat <= 32'h0;
      q.fl_start <= 1'b0;
      q.fl_op <= OP_LOAD;
      q.fl_addr <= '0;
      q.done <= 1'b0;
      q.ok <= 1'b0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign spm_done_o = q.done;
  assign spm_ok_o = q.ok;
  assign flash_start_o = q.fl_start;
  assign flash_op_o = q.fl_op;
  assign flash_addr_o = q.fl_addr;
  assign cpu_halt_o = q.halt;
  // stalling section stays readable, only concurrent reads are fenced
  assign rww_read_blocked_o = q.busy;

  logic lpm_lock_ok;
  // general read/write lock is not consulted for program loads
  always_comb begin
    lpm_lock_ok = 1'b1;
    if (dec_boot[2] && !dec_boot[3]) begin
      lpm_lock_ok = q.app_lock[1];
    end else if (!dec_boot[2] && dec_boot[3]) begin
      lpm_lock_ok = q.boot_lock[1];
    end
  end
  assign lpm_allow_o = lpm_lock_ok & ~(q.busy & ~dec_stalling_section[3]);

  assign irq_suppress_o = (ivec_in_boot_i & ~q.app_lock[1] & ~dec_boot[4]) |
                          (~ivec_in_boot_i & ~q.boot_lock[1] & dec_boot[4]);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_prog_start;
    ce_i && q.st == ST_IDLE && spm_req_i && pc_boot && spm_op_i inside {OP_ERASE, OP_WRITE} && store_allowed;
  endsequence
  sequence s_refused;
    ce_i && q.st == ST_IDLE && spm_req_i && (!pc_boot ||
      (spm_op_i inside {OP_ERASE, OP_WRITE} && !store_allowed));
  endsequence

  a_app_store_refused: assert property (s_refused |=> !flash_start_o && !spm_ok_o && spm_done_o)
    else $error("refused store had an effect");
  a_refused_quiet: assert property (s_refused ##0 (!q.busy && !q.halt) |=> !cpu_halt_o && !rww_read_blocked_o)
    else $error("refused store halted or set busy");
  a_stall_halts: assert property (s_prog_start ##0 tgt_stalling_section |=> cpu_halt_o && flash_start_o)
    else $error("stalling program did not halt cpu");
  a_halt_holds: assert property (cpu_halt_o && !flash_done_i |=> cpu_halt_o)
    else $error("halt released before completion");
  a_halt_release: assert property (ce_i && cpu_halt_o && flash_done_i |=> !cpu_halt_o && spm_done_o)
    else $error("halt not released at completion");
  a_rww_no_halt: assert property (s_prog_start ##0 !tgt_stalling_section |=> !cpu_halt_o && rww_read_blocked_o
    ##1 (rww_read_blocked_o || !ce_i || $past(rre_wr)))
    else $error("concurrent program stalled or not fenced");
  a_busy_load_clear: assert property (ce_i && q.st == ST_IDLE && spm_req_i && pc_boot && spm_op_i == OP_LOAD
    |=> !rww_read_blocked_o)
    else $error("page load did not clear busy");
  a_busy_kept_prog: assert property (rww_read_blocked_o && q.st == ST_PROG |=> rww_read_blocked_o)
    else $error("busy cleared while programming");
  a_lock_sticky: assert property (ce_i && !chip_erase_i |=> ((q.app_lock & ~$past(q.app_lock)) == 2'h0)
    && ((q.boot_lock & ~$past(q.boot_lock)) == 2'h0))
    else $error("lock bit unprogrammed without chip erase");
  a_app_write_lock: assert property (ce_i && spm_req_i && q.st == ST_IDLE && !tgt_boot && !q.app_lock[0]
    |=> !flash_start_o || flash_op_o inside {OP_LOAD})
    else $error("store to locked application section");
  a_boot_write_lock: assert property (ce_i && spm_req_i && q.st == ST_IDLE && tgt_boot && !q.boot_lock[0]
    |=> !flash_start_o || flash_op_o inside {OP_LOAD})
    else $error("store to locked boot section");
  a_lpm_cross_lock: assert property ((dec_boot[2] != dec_boot[3]) &&
    !(dec_boot[2] ? q.app_lock[1] : q.boot_lock[1]) |-> !lpm_allow_o)
    else $error("locked cross-section load allowed");
endmodule : fspg_guard

// *** fspg_flash_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// flash array stand-in: answers each start after delay_i edges
// ------------------------------------------------------------
module fspg_flash_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] delay_i,
  input wire logic flash_start_i,
  output logic flash_done_o
);
  logic [7:0] cnt_q;
  // done is a single pulse; a zero delay is not supported
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      flash_done_o <= 1'b0;
    end else begin
      flash_done_o <= (cnt_q == 8'h01);
      if (flash_start_i) begin
        cnt_q <= delay_i;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : fspg_flash_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import fspg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, dly = 8'h03;
  logic [3:0] wb_sel_i = 4'h0, spm_lock_i = 4'hf, prog_lock_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [1:0] boot_size_fuses_i = 2'h3;
  logic spm_req_i = 1'b0, spm_done_o, spm_ok_o, lpm_allow_o, irq_suppress_o;
  logic flash_start_o, flash_done_i, cpu_halt_o, rww_read_blocked_o;
  logic ivec_in_boot_i = 1'b0, prog_lock_we_i = 1'b0, chip_erase_i = 1'b0;
  fspg_op_t spm_op_i = OP_LOAD, flash_op_o;
  logic [15:0] spm_pc_i = 16'h0, spm_addr_i = 16'h0, lpm_pc_i = 16'h0;
  logic [15:0] lpm_addr_i = 16'h0, exec_pc_i = 16'h0, flash_addr_o;
  logic halt_seen, blk_seen, ok_seen;
  int n_fail = 0, check_count = 0, halt_n, f;
  localparam logic [15:0] BPC = 16'hff00, APC = 16'h0100;
  always #12.5 clk_i = ~clk_i;
  fspg_guard fspg_guard_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .boot_size_fuses_i(boot_size_fuses_i), .spm_req_i(spm_req_i), .spm_op_i(spm_op_i),
    .spm_pc_i(spm_pc_i), .spm_addr_i(spm_addr_i), .spm_lock_i(spm_lock_i),
    .spm_done_o(spm_done_o), .spm_ok_o(spm_ok_o), .lpm_pc_i(lpm_pc_i),
    .lpm_addr_i(lpm_addr_i), .lpm_allow_o(lpm_allow_o), .exec_pc_i(exec_pc_i),
    .ivec_in_boot_i(ivec_in_boot_i), .irq_suppress_o(irq_suppress_o),
    .prog_lock_we_i(prog_lock_we_i), .prog_lock_i(prog_lock_i), .chip_erase_i(chip_erase_i),
    .flash_start_o(flash_start_o), .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o),
    .flash_done_i(flash_done_i), .cpu_halt_o(cpu_halt_o), .rww_read_blocked_o(rww_read_blocked_o));
  fspg_flash_model fspg_flash_model_inst (.clk_i(clk_i), .rst_i(rst_i), .delay_i(dly),
    // page loads need no array time; answering them would end a later program early
    .flash_start_i(flash_start_o && (flash_op_o != OP_LOAD)), .flash_done_o(flash_done_i));
  // ------------------------------------------------------------
  // compare and close
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // bus and store-port drivers
  // ------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'h1;
    for (i = 0; i < 50 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 50) begin
      n_fail++;
      finish_test();
    end
  endtask : wb
  // lock data is taken from spm_lock_i as set by the caller
  task automatic store(input fspg_op_t op, input logic [15:0] pc, input logic [15:0] adr);
    int i;
    @(posedge clk_i);
    spm_req_i <= 1'b1;
    spm_op_i <= op;
    spm_pc_i <= pc;
    spm_addr_i <= adr;
    @(posedge clk_i);
    spm_req_i <= 1'b0;
    halt_seen = 1'b0;
    blk_seen = 1'b0;
    halt_n = 0;
    for (i = 0; i < 100; i++) begin
      @(negedge clk_i);
      halt_seen |= cpu_halt_o;
      blk_seen |= rww_read_blocked_o;
      halt_n += int'(cpu_halt_o === 1'b1);
      if (spm_done_o === 1'b1) break;
    end
    if (i == 100) begin
      n_fail++;
      finish_test();
    end
    ok_seen = spm_ok_o;
  endtask : store
  task automatic load_chk(input logic [15:0] pc, input logic [15:0] adr, input logic exp);
    lpm_pc_i <= pc;
    lpm_addr_i <= adr;
    @(negedge clk_i);
    chk(lpm_allow_o, exp);
  endtask : load_chk
  task automatic erase_chip();
    @(posedge clk_i);
    chip_erase_i <= 1'b1;
    @(posedge clk_i);
    chip_erase_i <= 1'b0;
  endtask : erase_chip
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_LOCK_OFS, 32'h0);
    chk(rd, 32'hf);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    store(OP_ERASE, APC, 16'hf800);
    chk({halt_seen, blk_seen, ok_seen}, 3'h0);
    dly = 8'h14;
    store(OP_ERASE, BPC, 16'hf800);
    chk({ok_seen, cpu_halt_o, blk_seen}, 3'h4);
    chk(halt_n >= 20, 1'b1);
    dly = 8'h03;
    store(OP_WRITE, BPC, 16'h1000);
    chk({halt_seen, rww_read_blocked_o, ok_seen}, 3'h3);
    wb(1'b0, REG_STAT_OFS, 32'h0);
    chk(rd[STAT_BUSY_BIT], 1'b1);
    load_chk(BPC, 16'h1000, 1'b0);
    load_chk(BPC, 16'hf800, 1'b1);
    // busy is cleared before any code in that section is read again
    wb(1'b1, REG_CTRL_OFS, 32'h1);
    repeat (2) @(negedge clk_i);
    chk(rww_read_blocked_o, 1'b0);
    store(OP_WRITE, BPC, 16'h2000);
    store(OP_LOAD, BPC, 16'h2000);
    @(negedge clk_i);
    chk(rww_read_blocked_o, 1'b0);
    store(OP_WRITE, BPC, 16'hfe10);
    chk({ok_seen, halt_seen, blk_seen}, 3'h6);
    chk(flash_addr_o, 16'hfe10);
    // fixed boundary at word 0xf000, whatever the boot size
    for (f = 0; f < 4; f++) begin
      boot_size_fuses_i <= 2'(f);
      store(OP_ERASE, BPC, 16'hf000);
      chk(halt_seen, 1'b1);
      store(OP_ERASE, BPC, 16'hefff);
      chk({halt_seen, blk_seen}, 2'h1);
    end
    wb(1'b1, REG_CTRL_OFS, 32'h1);
    boot_size_fuses_i <= 2'h0;
    store(OP_ERASE, 16'hf100, 16'hf000);
    chk(ok_seen, 1'b1);
    boot_size_fuses_i <= 2'h3;
    store(OP_ERASE, 16'hf100, 16'hf000);
    chk(ok_seen, 1'b0);
    wb(1'b1, REG_LOCK_OFS, 32'he);
    store(OP_ERASE, APC, 16'h0100);
    store(OP_ERASE, BPC, 16'h0100);
    chk({ok_seen, halt_seen, blk_seen}, 3'h0);
    store(OP_ERASE, BPC, 16'hfe00);
    chk(ok_seen, 1'b1);
    load_chk(BPC, 16'h0100, 1'b1);
    wb(1'b1, REG_LOCK_OFS, 32'hd);
    wb(1'b1, REG_LOCK_OFS, 32'hf);
    wb(1'b0, REG_LOCK_OFS, 32'h0);
    chk(rd, 32'hc);
    load_chk(BPC, 16'h0100, 1'b0);
    exec_pc_i <= APC;
    ivec_in_boot_i <= 1'b1;
    @(negedge clk_i);
    chk(irq_suppress_o, 1'b1);
    erase_chip();
    wb(1'b0, REG_LOCK_OFS, 32'h0);
    chk(rd, 32'hf);
    @(posedge clk_i);
    prog_lock_we_i <= 1'b1;
    prog_lock_i <= 4'hd;
    @(posedge clk_i);
    prog_lock_we_i <= 1'b0;
    load_chk(BPC, 16'h0100, 1'b0);
    store(OP_WRITE, BPC, 16'h0100);
    chk(ok_seen, 1'b1);
    spm_lock_i <= 4'hb;
    store(OP_LOCKSET, BPC, 16'h0000);
    wb(1'b0, REG_LOCK_OFS, 32'h0);
    chk(rd, 32'h9);
    store(OP_WRITE, BPC, 16'hfe00);
    chk({ok_seen, halt_seen}, 2'h0);
    load_chk(APC, 16'hff80, 1'b1);
    wb(1'b1, REG_LOCK_OFS, 32'h1);
    load_chk(APC, 16'hff80, 1'b0);
    exec_pc_i <= BPC;
    ivec_in_boot_i <= 1'b0;
    @(negedge clk_i);
    chk(irq_suppress_o, 1'b1);
    erase_chip();
    wb(1'b1, REG_LOCK_OFS, 32'h7);
    load_chk(APC, 16'hff80, 1'b0);
    store(OP_WRITE, BPC, 16'hfe00);
    chk(ok_seen, 1'b1);
    finish_test();
  end
endmodule : tb
